/* File: occ_sync.sv */
package occ_pkg;
  localparam int          TMR_W      = 16;
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  ADDR_CMP   = 8'h04;
  localparam logic [7:0]  ADDR_CMPS  = 8'h08;
  localparam logic [7:0]  ADDR_STS   = 8'h0C;
  localparam logic [7:0]  ADDR_MASK  = 8'h10;
  localparam int          BIT_SIDL   = 13;
  localparam int          BIT_FLT    = 4;
  localparam int          BIT_TSEL   = 3;
  localparam int          STS_CMP    = 0;
  localparam int          STS_FLT    = 1;
  localparam int          STS_W      = 2;
  localparam logic [2:0]  MODE_OFF   = 3'h0;
  localparam logic [2:0]  MODE_LH    = 3'h1;
  localparam logic [2:0]  MODE_HL    = 3'h2;
  localparam logic [2:0]  MODE_TOG   = 3'h3;
  localparam logic [2:0]  MODE_ONE   = 3'h4;
  localparam logic [2:0]  MODE_CONT  = 3'h5;
  localparam logic [2:0]  MODE_PWM   = 3'h6;
  localparam logic [2:0]  MODE_PWMF  = 3'h7;
  localparam logic [15:0] CMP_RST    = 16'h0000;
  localparam logic [1:0]  STS_RST    = 2'h0;
  localparam logic [1:0]  MASK_RST   = 2'h0;
  localparam logic        FAULT_RST  = 1'b1;
endpackage : occ_pkg

`timescale 1ns/1ps
module occ_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      meta_reg <= RST_VAL;
      q_out    <= RST_VAL;
    end else if (ce_in) begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule : occ_sync

/* File: occ_output_compare.sv */
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module occ_output_compare
  import occ_pkg::*;
(
  input  wire logic              CLK_SYS_IN,
  input  wire logic              RSTN_IN,
  input  wire logic              CE_IN,
  input  wire logic              PSEL_IN,
  input  wire logic              PENABLE_IN,
  input  wire logic              PWRITE_IN,
  input  wire logic [ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]       PWDATA_IN,
  output logic      [31:0]       PRDATA_OUT,
  output logic                   PREADY_OUT,
  output logic                   PSLVERR_OUT,
  input  wire logic              IDLE_IN,
  input  wire logic [TMR_W-1:0]  TMR2_IN,
  input  wire logic [TMR_W-1:0]  TMR3_IN,
  input  wire logic              FAULT_N_IN,
  output logic                   CMP_OUT,
  output logic                   IRQ_OUT
);
  logic             sidl_reg;
  logic             tsel_reg;
  logic [2:0]       mode_reg;
  logic [2:0]       mode_prev_reg;
  logic             flt_reg;
  logic [TMR_W-1:0] cmp_reg;
  logic [TMR_W-1:0] cmps_reg;
  logic [STS_W-1:0] sts_reg;
  logic [STS_W-1:0] mask_reg;
  logic             match_prev_reg;
  logic             matchs_prev_reg;
  logic             zero_prev_reg;
  logic             fault_prev_reg;
  logic             done_reg;
  logic             done_next;
  logic             out_next;
  logic             fault_s;
  logic             run;
  logic             mode_chg;
  logic [TMR_W-1:0] timer;
  logic             match;
  logic             matchs;
  logic             ev;
  logic             evs;
  logic             period;
  logic             fault_fall;
  logic             rise;
  logic             fall;
  logic             cmp_irq;
  logic             flt_irq;
  logic             setup;
  logic             acc;
  logic             acc_wr;
  logic             rd_sts;
  logic             mapped;
  logic             irq_any;
  logic [31:0]      rdata;

  // The fault pin is asynchronous and active low.
  occ_sync #(
    .W       (1),
    .RST_VAL (FAULT_RST)
  ) u_fault_sync (
    .clk_in  (CLK_SYS_IN),
    .rstn_in (RSTN_IN),
    .ce_in   (CE_IN),
    .d_in    (FAULT_N_IN),
    .q_out   (fault_s)
  );

  assign run        = CE_IN && !(IDLE_IN && sidl_reg);
  assign timer      = tsel_reg ? TMR3_IN : TMR2_IN;
  assign match      = (timer == cmp_reg);
  assign matchs     = (timer == cmps_reg);
  // A stopped timer holds its value, so only the first matching cycle counts.
  assign ev         = match && !match_prev_reg;
  assign evs        = matchs && !matchs_prev_reg;
  assign period     = (timer == '0) && !zero_prev_reg;
  assign mode_chg   = (mode_reg != mode_prev_reg);
  assign fault_fall = fault_prev_reg && !fault_s;

  always_comb begin
    out_next  = CMP_OUT;
    done_next = done_reg;
    if (mode_chg) begin
      done_next = 1'b0;
      unique case (mode_reg)
        MODE_OFF:  out_next = 1'b0;
        MODE_LH:   out_next = 1'b0;
        MODE_HL:   out_next = 1'b1;
        MODE_TOG:  out_next = CMP_OUT;
        MODE_ONE:  out_next = 1'b0;
        MODE_CONT: out_next = 1'b0;
        MODE_PWM:  out_next = (cmp_reg != '0);
        MODE_PWMF: out_next = (cmp_reg != '0) && !(flt_reg || fault_fall);
      endcase
    end else begin
      unique case (mode_reg)
        MODE_OFF: out_next = 1'b0;
        MODE_LH: begin
          if (ev) out_next = 1'b1;
        end
        MODE_HL: begin
          if (ev) out_next = 1'b0;
        end
        MODE_TOG: begin
          if (ev) out_next = !CMP_OUT;
        end
        MODE_ONE: begin
          if (!done_reg) begin
            if (ev) out_next = 1'b1;
            if (evs && CMP_OUT) begin
              out_next  = 1'b0;
              done_next = 1'b1;
            end
          end
        end
        MODE_CONT: begin
          if (ev) out_next = 1'b1;
          if (evs) out_next = 1'b0;
        end
        MODE_PWM: begin
          if (period) out_next = (cmp_reg != '0);
          else if (ev) out_next = 1'b0;
        end
        MODE_PWMF: begin
          if (period) out_next = (cmp_reg != '0);
          else if (ev) out_next = 1'b0;
          if (flt_reg || fault_fall) out_next = 1'b0;
        end
      endcase
    end
  end

  assign rise = out_next && !CMP_OUT && !mode_chg;
  assign fall = !out_next && CMP_OUT && !mode_chg;

  always_comb begin
    unique case (mode_reg)
      MODE_LH:                       cmp_irq = rise;
      MODE_HL, MODE_ONE, MODE_CONT:  cmp_irq = fall;
      MODE_TOG:                      cmp_irq = rise || fall;
      default:                       cmp_irq = 1'b0;
    endcase
  end

  assign flt_irq = (mode_reg == MODE_PWMF) && fault_fall;

  // Channel state advances only while running; control writes land anyway.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      CMP_OUT         <= 1'b0;
      done_reg        <= 1'b0;
      mode_prev_reg   <= MODE_OFF;
      match_prev_reg  <= 1'b0;
      matchs_prev_reg <= 1'b0;
      zero_prev_reg   <= 1'b0;
      fault_prev_reg  <= FAULT_RST;
    end else if (run) begin
      CMP_OUT         <= out_next;
      done_reg        <= done_next;
      mode_prev_reg   <= mode_reg;
      match_prev_reg  <= match;
      matchs_prev_reg <= matchs;
      zero_prev_reg   <= (timer == '0);
      fault_prev_reg  <= fault_s;
    end
  end

  // The flag is never written by software; it clears once mode 111 is left.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      flt_reg <= 1'b0;
    end else if (run) begin
      if (mode_reg != MODE_PWMF) flt_reg <= 1'b0;
      else if (fault_fall) flt_reg <= 1'b1;
    end
  end

  assign setup  = PSEL_IN && !PENABLE_IN;
  assign acc    = PSEL_IN && PENABLE_IN && PREADY_OUT;
  assign acc_wr = acc && PWRITE_IN && !PSLVERR_OUT;
  assign rd_sts = acc && !PWRITE_IN && (PADDR_IN == ADDR_STS);
  assign mapped = (PADDR_IN == ADDR_CTRL) || (PADDR_IN == ADDR_CMP) ||
                  (PADDR_IN == ADDR_CMPS) || (PADDR_IN == ADDR_STS) ||
                  (PADDR_IN == ADDR_MASK);

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      sidl_reg <= 1'b0;
      tsel_reg <= 1'b0;
      mode_reg <= MODE_OFF;
      cmp_reg  <= CMP_RST;
      cmps_reg <= CMP_RST;
      mask_reg <= MASK_RST;
    end else if (CE_IN && acc_wr) begin
      unique case (PADDR_IN)
        ADDR_CTRL: begin
          sidl_reg <= PWDATA_IN[BIT_SIDL];
          tsel_reg <= PWDATA_IN[BIT_TSEL];
          mode_reg <= PWDATA_IN[2:0];
        end
        ADDR_CMP:  cmp_reg  <= PWDATA_IN[TMR_W-1:0];
        ADDR_CMPS: cmps_reg <= PWDATA_IN[TMR_W-1:0];
        ADDR_MASK: mask_reg <= PWDATA_IN[STS_W-1:0];
        default: ;
      endcase
    end
  end

  // A read clears only the bits it returned, and a new event wins over that clear.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      sts_reg <= STS_RST;
    end else if (CE_IN) begin
      sts_reg <= (rd_sts ? sts_reg & ~PRDATA_OUT[STS_W-1:0] : sts_reg)
                 | {run && flt_irq, run && cmp_irq};
    end
  end

  assign irq_any = |(sts_reg & mask_reg);

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      IRQ_OUT <= 1'b0;
    end else if (CE_IN) begin
      IRQ_OUT <= irq_any;
    end
  end

  always_comb begin
    rdata = '0;
    unique case (PADDR_IN)
      ADDR_CTRL: begin
        rdata[BIT_SIDL] = sidl_reg;
        rdata[BIT_FLT]  = flt_reg;
        rdata[BIT_TSEL] = tsel_reg;
        rdata[2:0]      = mode_reg;
      end
      ADDR_CMP:  rdata[TMR_W-1:0] = cmp_reg;
      ADDR_CMPS: rdata[TMR_W-1:0] = cmps_reg;
      ADDR_STS:  rdata[STS_W-1:0] = sts_reg;
      ADDR_MASK: rdata[STS_W-1:0] = mask_reg;
      default:   rdata = '0;
    endcase
  end

  // Zero-wait slave: read data is captured in the setup cycle.
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= '0;
    end else if (CE_IN) begin
      PREADY_OUT  <= setup;
      PSLVERR_OUT <= setup && !mapped;
      if (setup) PRDATA_OUT <= rdata;
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);

  a_ctrl_zero_bits: assert property (
    (PREADY_OUT && PADDR_IN == ADDR_CTRL)
      |-> (PRDATA_OUT[15:14] == 2'h0 && PRDATA_OUT[12:5] == 8'h00))
    else $error("unused control bits read nonzero");

  a_idle_halt_hold: assert property (
    (CE_IN && IDLE_IN && sidl_reg) |=> $stable(CMP_OUT) && $stable(done_reg))
    else $error("channel moved while halted in idle");

  a_off_quiet: assert property (
    (run && mode_reg == MODE_OFF) |=> !CMP_OUT)
    else $error("disabled channel drove output");

  a_lh_force_high: assert property (
    (run && !mode_chg && mode_reg == MODE_LH && ev) |=> CMP_OUT)
    else $error("mode 001 event did not force high");

  a_hl_init_high: assert property (
    (run && mode_chg && mode_reg == MODE_HL)
      |=> CMP_OUT ##1 (CMP_OUT || $past(ev) || $past(mode_chg)))
    else $error("mode 010 did not start high");

  a_toggle_flip: assert property (
    (run && !mode_chg && mode_reg == MODE_TOG && ev) |=> CMP_OUT != $past(CMP_OUT))
    else $error("toggle event did not invert output");

  a_single_pulse_done: assert property (
    (run && mode_reg == MODE_ONE && done_reg && !mode_chg) |=> !CMP_OUT)
    else $error("second pulse in single pulse mode");

  a_cont_fall: assert property (
    (run && !mode_chg && mode_reg == MODE_CONT && evs && !ev) |=> !CMP_OUT)
    else $error("continuous pulse did not end on second match");

  a_pwm_no_irq: assert property (
    (run && mode_reg == MODE_PWM) |-> !cmp_irq && !flt_irq)
    else $error("interrupt event in unprotected pwm");

  a_fault_record: assert property (
    (run && mode_reg == MODE_PWMF && fault_fall) |=> flt_reg && !CMP_OUT && sts_reg[STS_FLT])
    else $error("fault not recorded");

  a_fault_only_pwmf: assert property (
    (run && mode_reg != MODE_PWMF) |=> !flt_reg)
    else $error("fault flag held outside mode 111");

  a_fault_hw_only: assert property (
    (acc_wr && PADDR_IN == ADDR_CTRL && mode_reg == MODE_PWMF && !fault_fall)
      |=> $stable(flt_reg))
    else $error("software changed fault flag");

  a_pwm_init_level: assert property (
    (run && mode_chg && mode_reg[2:1] == 2'b11)
      |=> CMP_OUT == (($past(cmp_reg) != '0) && !flt_reg))
    else $error("pwm initial level wrong");

  a_irq_level: assert property (
    CE_IN |=> IRQ_OUT == $past(irq_any))
    else $error("interrupt output does not follow masked status");

  a_timebase_pick: assert property (
    ((tsel_reg && TMR3_IN != cmp_reg) || (!tsel_reg && TMR2_IN != cmp_reg)) |-> !match)
    else $error("compare used the wrong timer");

  a_fault_hold_low: assert property (
    (run && !mode_chg && mode_reg == MODE_PWMF && flt_reg) |=> !CMP_OUT)
    else $error("output rose while fault flag set");

  a_toggle_irq_set: assert property (
    (run && !mode_chg && mode_reg == MODE_TOG && ev) |=> sts_reg[STS_CMP])
    else $error("toggle edge did not set status");

  a_cont_fall_irq: assert property (
    (run && !mode_chg && mode_reg == MODE_CONT && evs && !ev && CMP_OUT)
      |=> sts_reg[STS_CMP])
    else $error("continuous pulse fall did not set status");

  c_toggle: cover property (run && mode_reg == MODE_TOG && ev);
  c_idle_halt: cover property (CE_IN && IDLE_IN && sidl_reg && mode_reg != MODE_OFF);
  c_fault: cover property (run && mode_reg == MODE_PWMF && fault_fall);
  c_pulse_done: cover property (run && mode_reg == MODE_ONE && done_next && !done_reg);
  c_read_clear: cover property (rd_sts && sts_reg != STS_RST);
endmodule : occ_output_compare

/* File: occ_far_model.sv */
`timescale 1ns/1ps
module occ_far_model
  import occ_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             run_in,
  input  wire logic             flt_in,
  output logic      [TMR_W-1:0] tmr2_out,
  output logic      [TMR_W-1:0] tmr3_out,
  output logic                  fault_n_out
);
  // A stopped timer is also cleared, so every run starts from zero.
  always_ff @(posedge clk_in) begin
    if (!rstn_in || !run_in) begin
      tmr2_out <= '0;
    end else begin
      tmr2_out <= (tmr2_out == 16'h003F) ? 16'h0000 : tmr2_out + 16'h0001;
    end
  end
  // The third timer never shares a value with the second one.
  assign tmr3_out    = tmr2_out + 16'h0100;
  assign fault_n_out = !flt_in;
endmodule : occ_far_model

/* File: testbench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); \
  end \
end
module testbench
  import occ_pkg::*;
;
  logic        clk = '0, rstn = '0, psel = '0, penable = '0, pwrite = '0;
  logic        idle = '0, run = '0, flt = '0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, cmp, irq, fault_n;
  logic [15:0] t2, t3;
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;

  always #4 clk = ~clk;

  occ_output_compare occ_output_compare_inst (
    .CLK_SYS_IN(clk), .RSTN_IN(rstn), .CE_IN(1'b1), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .IDLE_IN(idle), .TMR2_IN(t2), .TMR3_IN(t3),
    .FAULT_N_IN(fault_n), .CMP_OUT(cmp), .IRQ_OUT(irq)
  );

  occ_far_model occ_far_model_inst (
    .clk_in(clk), .rstn_in(rstn), .run_in(run), .flt_in(flt),
    .tmr2_out(t2), .tmr3_out(t3), .fault_n_out(fault_n)
  );

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdchk

  // Stops the timer, loads both compare values and the control word.
  task automatic arm(input logic [31:0] ctl, input logic [15:0] c, input logic [15:0] cs);
    @(posedge clk);
    run <= 1'b0;
    apb(1'b1, ADDR_CMP, {16'h0000, c});
    apb(1'b1, ADDR_CMPS, {16'h0000, cs});
    apb(1'b1, ADDR_CTRL, ctl);
    apb(1'b0, ADDR_STS, 32'h0);
    @(negedge clk);
  endtask : arm

  task automatic go();
    @(posedge clk);
    run <= 1'b1;
    @(negedge clk);
  endtask : go

  task automatic wait_lvl(input logic lvl);
    int n;
    n = 0;
    while (cmp !== lvl && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_lvl

  task automatic edge_at(input logic lvl, input logic sel, input logic [15:0] e);
    wait_lvl(lvl);
    `CHK(cmp, lvl)
    `CHK(sel ? t3 : t2, e)
  endtask : edge_at

  task automatic hold(input logic lvl, input int cycles);
    logic bad;
    bad = 1'b0;
    repeat (cycles) begin
      @(negedge clk);
      if (cmp !== lvl) bad = 1'b1;
    end
    `CHK(bad, 1'b0)
  endtask : hold

  task automatic evt(input logic [31:0] s);
    @(negedge clk);
    `CHK(irq, 1'b1)
    rdchk(ADDR_STS, s);
  endtask : evt

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rdchk(ADDR_CTRL, 32'h0);
    rdchk(ADDR_CMP, 32'h0);
    rdchk(ADDR_MASK, 32'h0);
    rdchk(8'h20, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
    rdchk(ADDR_CTRL, 32'h0000_200F);
    apb(1'b1, ADDR_MASK, 32'h3);
    arm(32'h1, 16'h0010, 16'h0000);
    `CHK(cmp, 1'b0)
    go();
    edge_at(1'b1, 1'b0, 16'h0011);
    evt(32'h1);
    hold(1'b1, 80);
    arm(32'h0, 16'h0010, 16'h0000);
    go();
    hold(1'b0, 100);
    arm(32'h2, 16'h0010, 16'h0000);
    `CHK(cmp, 1'b1)
    go();
    edge_at(1'b0, 1'b0, 16'h0011);
    evt(32'h1);
    arm(32'h3, 16'h0010, 16'h0000);
    `CHK(cmp, 1'b0)
    go();
    edge_at(1'b1, 1'b0, 16'h0011);
    evt(32'h1);
    edge_at(1'b0, 1'b0, 16'h0011);
    evt(32'h1);
    arm(32'h2003, 16'h0010, 16'h0000);
    @(posedge clk);
    idle <= 1'b1;
    go();
    hold(1'b0, 100);
    arm(32'h3, 16'h0010, 16'h0000);
    go();
    edge_at(1'b1, 1'b0, 16'h0011);
    @(posedge clk);
    idle <= 1'b0;
    arm(32'h3, 16'h0110, 16'h0000);
    go();
    hold(1'b1, 100);
    arm(32'hB, 16'h0110, 16'h0000);
    go();
    edge_at(1'b0, 1'b1, 16'h0111);
    arm(32'h4, 16'h0010, 16'h0020);
    `CHK(cmp, 1'b0)
    go();
    edge_at(1'b1, 1'b0, 16'h0011);
    edge_at(1'b0, 1'b0, 16'h0021);
    evt(32'h1);
    hold(1'b0, 140);
    arm(32'h5, 16'h0010, 16'h0020);
    go();
    repeat (2) begin
      edge_at(1'b1, 1'b0, 16'h0011);
      edge_at(1'b0, 1'b0, 16'h0021);
      evt(32'h1);
    end
    arm(32'h6, 16'h0020, 16'h0000);
    `CHK(cmp, 1'b1)
    go();
    @(posedge clk);
    flt <= 1'b1;
    edge_at(1'b0, 1'b0, 16'h0021);
    edge_at(1'b1, 1'b0, 16'h0001);
    rdchk(ADDR_STS, 32'h0);
    @(posedge clk);
    flt <= 1'b0;
    apb(1'b1, ADDR_MASK, 32'h2);
    arm(32'h7, 16'h0020, 16'h0000);
    `CHK(cmp, 1'b1)
    rdchk(ADDR_CTRL, 32'h7);
    go();
    repeat (10) @(posedge clk);
    flt <= 1'b1;
    wait_lvl(1'b0);
    repeat (4) @(negedge clk);
    `CHK(irq, 1'b1)
    rdchk(ADDR_CTRL, 32'h17);
    apb(1'b0, ADDR_STS, 32'h0);
    `CHK(rd[STS_FLT], 1'b1)
    hold(1'b0, 100);
    arm(32'h7, 16'h0020, 16'h0000);
    rdchk(ADDR_CTRL, 32'h17);
    @(posedge clk);
    flt <= 1'b0;
    arm(32'h6, 16'h0020, 16'h0000);
    rdchk(ADDR_CTRL, 32'h6);
    summarize();
  end
endmodule : testbench
